// ===== rtl/fcd_map.vh
// Purpose: Constants for the front-end chip download serializer
// Assumes: 20 MHz system clock
// Notes: Included by rtl/fcd_download.v
`ifndef FCD_MAP_VH
`define FCD_MAP_VH

// ----------------------------------------
// Chip and chain geometry
// ----------------------------------------
`define FCD_REC_BITS 182
`define FCD_CHIPS_PER_CHAIN 10
`define FCD_CHAINS 8
`define FCD_CHAINS_PER_GROUP 4
`define FCD_GROUPS 2

// ----------------------------------------
// Serial word link timing
// ----------------------------------------
`define FCD_WORD_BITS 20
`define FCD_BIT_NS 1000
`define FCD_CLK_NS 50
`define FCD_WORD_CYC ((`FCD_WORD_BITS * `FCD_BIT_NS) / `FCD_CLK_NS)
`define FCD_WORDS_PER_XFER 32
`define FCD_PAYLOAD_BITS 16

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define FCD_CMD_RT_HI 15
`define FCD_CMD_RT_LO 11
`define FCD_CMD_TR 10
`define FCD_CMD_SUB_HI 9
`define FCD_CMD_SUB_LO 5
`define FCD_CMD_CNT_HI 4
`define FCD_CMD_CNT_LO 0
`define FCD_SUB_BASE 5'h01
`define FCD_MAX_RT 5'h1e
`define FCD_MAX_SUB 5'h1e

// ----------------------------------------
// Shifter states, one-hot
// ----------------------------------------
`define FCD_SH_IDLE 3'h1
`define FCD_SH_SETUP 3'h2
`define FCD_SH_EDGE 3'h4

`endif

// ===== rtl/fcd_download.v
// Purpose: Serial configuration downloader for daisy-chained front-end chips
// Assumes: Host ports are on clk_sys; download_enable and chain_return are pins
// Notes: Backplane writes load all chains at once; serial word link fills one group chain by chain
`timescale 1ns/1ps
`include "fcd_map.vh"

module fcd_download #(
    parameter REC_BITS = `FCD_REC_BITS,
    parameter CHIPS_PER_CHAIN = `FCD_CHIPS_PER_CHAIN,
    parameter CHAINS_PER_GROUP = `FCD_CHAINS_PER_GROUP,
    parameter WORD_CYC = `FCD_WORD_CYC
) (
    input wire clk_sys,
    input wire rst_n,
    input wire download_enable,
    input wire bp_write,
    input wire bp_read,
    input wire [7:0] bp_wdata,
    output reg bp_dtack,
    output reg [7:0] bp_rdata,
    output reg bp_rvalid,
    input wire [4:0] rt_address,
    input wire [3:0] rt_bit_select,
    input wire rt_word_valid,
    input wire rt_word_is_cmd,
    input wire [15:0] rt_word,
    output reg rt_overrun,
    input wire [7:0] chain_return,
    output reg [7:0] chain_data,
    output reg [7:0] chain_clk,
    output reg init_mode,
    output reg [1:0] group_done,
    output reg config_lost
);

localparam [31:0] CHAIN_BITS = REC_BITS * CHIPS_PER_CHAIN;
localparam [10:0] LAST_BIT = CHAIN_BITS[10:0] - 11'h001;
localparam [31:0] CHAINS_M1 = CHAINS_PER_GROUP - 1;
localparam [1:0] LAST_CHAIN = CHAINS_M1[1:0];
localparam [31:0] GAP_FULL = 2 * WORD_CYC;
localparam [9:0] GAP_CYC = GAP_FULL[9:0];

// ----------------------------------------
// Shifter states, one-hot
// ----------------------------------------
localparam [2:0] SH_IDLE = `FCD_SH_IDLE;
localparam [2:0] SH_SETUP = `FCD_SH_SETUP;
localparam [2:0] SH_EDGE = `FCD_SH_EDGE;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
wire [8:0] pin_in;
reg [8:0] pin_s1;
reg [8:0] pin_s2;
reg [8:0] pin_s3;
reg [8:0] pin_q;
assign pin_in = {download_enable, chain_return};

// A pin change counts once the second and third stages agree
genvar gi;
generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
        always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pin_s1[gi] <= 1'b0;
                pin_s2[gi] <= 1'b0;
                pin_s3[gi] <= 1'b0;
                pin_q[gi] <= 1'b0;
            end else begin
                pin_s1[gi] <= pin_in[gi];
                pin_s2[gi] <= pin_s1[gi];
                pin_s3[gi] <= pin_s2[gi];
                if (pin_s2[gi] == pin_s3[gi]) begin
                    pin_q[gi] <= pin_s3[gi];
                end
            end
        end
    end
endgenerate

wire dl_en = pin_q[8];
wire [7:0] ret_bits = pin_q[7:0];
wire dl_start = dl_en & ~init_mode;

// ----------------------------------------
// Two-entry buffer: {read, mask, data}
// ----------------------------------------
reg [16:0] buf_mem [0:1];
reg buf_wp;
reg buf_rp;
reg [1:0] buf_cnt;
wire buf_full = (buf_cnt == 2'h2);
wire buf_empty = (buf_cnt == 2'h0);
reg [2:0] sh_state;
// Exit side offers an entry while one is held; the shifter takes it only when idle
wire out_valid = ~buf_empty;
wire out_ready = (sh_state == SH_IDLE);
wire pop = out_valid & out_ready;

reg rt_push;
// Payload bit is latched with its word, since rt_word is only valid during the strobe
reg rt_data;
reg [7:0] rt_mask;
wire rt_bit = rt_word[rt_bit_select];
// Serial words cannot be stalled, so they win the buffer over the backplane
wire bp_take = init_mode & (bp_write | bp_read) & ~bp_dtack & ~buf_full & ~rt_push;
wire in_valid = bp_take | rt_push;
wire in_ready = ~buf_full;
wire push = in_valid & in_ready;
wire [16:0] push_entry = rt_push ? {1'b0, rt_mask, {8{rt_data}} & rt_mask}
                                 : {bp_read & ~bp_write, 8'hff, bp_read & ~bp_write ? 8'h00 : bp_wdata};

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        buf_mem[0] <= 17'h00000;
        buf_mem[1] <= 17'h00000;
        buf_wp <= 1'b0;
        buf_rp <= 1'b0;
        buf_cnt <= 2'h0;
        bp_dtack <= 1'b0;
        rt_overrun <= 1'b0;
    end else begin
        if (push) begin
            buf_mem[buf_wp] <= push_entry;
            buf_wp <= ~buf_wp;
        end
        if (pop) begin
            buf_rp <= ~buf_rp;
        end
        buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        bp_dtack <= bp_take;
        if (rt_push & buf_full) begin
            rt_overrun <= 1'b1;
        end else if (dl_start) begin
            rt_overrun <= 1'b0;
        end
    end
end

// ----------------------------------------
// Serial word link receiver
// ----------------------------------------
reg rx_active;
reg rx_group;
reg [5:0] rx_left;
reg [9:0] rx_gap;
reg [1:0] grp_chain [0:1];
reg [10:0] grp_bits [0:1];

wire [4:0] cmd_rt = rt_word[`FCD_CMD_RT_HI:`FCD_CMD_RT_LO];
wire [4:0] cmd_sub = rt_word[`FCD_CMD_SUB_HI:`FCD_CMD_SUB_LO];
wire [4:0] cmd_cnt = rt_word[`FCD_CMD_CNT_HI:`FCD_CMD_CNT_LO];
wire sub_ok = (cmd_sub == `FCD_SUB_BASE) | (cmd_sub == `FCD_SUB_BASE + 5'h01);
wire cmd_hit = (cmd_rt == rt_address) & (cmd_rt <= `FCD_MAX_RT) & sub_ok
             & (cmd_sub <= `FCD_MAX_SUB) & ~rt_word[`FCD_CMD_TR];
wire grp_sel = (cmd_sub != `FCD_SUB_BASE);
wire [1:0] cur_chain = grp_chain[rx_group];
wire [10:0] cur_bits = grp_bits[rx_group];
wire [2:0] chain_sel = {rx_group, cur_chain};

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        rx_active <= 1'b0;
        rx_group <= 1'b0;
        rx_left <= 6'h00;
        rx_gap <= 10'h000;
        rt_push <= 1'b0;
        rt_data <= 1'b0;
        rt_mask <= 8'h00;
        grp_chain[0] <= 2'h0;
        grp_chain[1] <= 2'h0;
        grp_bits[0] <= 11'h000;
        grp_bits[1] <= 11'h000;
        group_done <= 2'h0;
    end else begin
        rt_push <= 1'b0;
        if (dl_start) begin
            rx_active <= 1'b0;
            grp_chain[0] <= 2'h0;
            grp_chain[1] <= 2'h0;
            grp_bits[0] <= 11'h000;
            grp_bits[1] <= 11'h000;
            group_done <= 2'h0;
        end else if (~init_mode) begin
            // Loading stops as soon as download_enable drops
            rx_active <= 1'b0;
        end else if (rt_word_valid & rt_word_is_cmd) begin
            // Any command ends the open transfer; only a matching receive command opens one
            rx_active <= cmd_hit & init_mode;
            rx_group <= grp_sel;
            // A count field of zero asks for a full 32-word transfer
            rx_left <= (cmd_cnt == 5'h00) ? 6'h20 : {1'b0, cmd_cnt};
            rx_gap <= 10'h000;
        end else if (rt_word_valid & rx_active) begin
            rx_gap <= 10'h000;
            rx_left <= rx_left - 6'h01;
            if (rx_left == 6'h01) begin
                rx_active <= 1'b0;
            end
            // A filled group ignores further words until download_enable rises again
            if (~group_done[rx_group]) begin
                rt_push <= 1'b1;
                rt_data <= rt_bit;
                rt_mask <= 8'h01 << chain_sel;
                if (cur_bits == LAST_BIT) begin
                    grp_bits[rx_group] <= 11'h000;
                    grp_chain[rx_group] <= cur_chain + 2'h1;
                    if (cur_chain == LAST_CHAIN) begin
                        group_done[rx_group] <= 1'b1;
                    end
                end else begin
                    grp_bits[rx_group] <= cur_bits + 11'h001;
                end
            end
        end else if (rx_active) begin
            // A silent link for two word times abandons the transfer
            rx_gap <= rx_gap + 10'h001;
            if (rx_gap == GAP_CYC) begin
                rx_active <= 1'b0;
            end
        end
    end
end

// ----------------------------------------
// Chain shifter
// ----------------------------------------
reg [16:0] sh_entry;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        sh_state <= SH_IDLE;
        sh_entry <= 17'h00000;
        chain_data <= 8'h00;
        chain_clk <= 8'h00;
        bp_rdata <= 8'h00;
        bp_rvalid <= 1'b0;
        config_lost <= 1'b0;
        init_mode <= 1'b0;
    end else begin
        init_mode <= dl_en;
        bp_rvalid <= 1'b0;
        case (sh_state)
            SH_IDLE: begin
                chain_clk <= 8'h00;
                if (pop) begin
                    sh_entry <= buf_mem[buf_rp];
                    // Only selected chains take a new bit; the rest hold theirs
                    chain_data <= (chain_data & ~buf_mem[buf_rp][15:8])
                                | (buf_mem[buf_rp][7:0] & buf_mem[buf_rp][15:8]);
                    sh_state <= SH_SETUP;
                end
            end
            SH_SETUP: begin
                // Clock rises a cycle after the data so every chain sees a settled bit
                chain_clk <= sh_entry[15:8];
                if (sh_entry[16]) begin
                    // Return pins lag by the filter depth; a read must trail the last shift by five cycles
                    bp_rdata <= ret_bits;
                    bp_rvalid <= 1'b1;
                    config_lost <= 1'b1;
                end else begin
                    config_lost <= 1'b0;
                end
                sh_state <= SH_EDGE;
            end
            SH_EDGE: begin
                chain_clk <= 8'h00;
                sh_state <= SH_IDLE;
            end
            default: begin
                chain_clk <= 8'h00;
                sh_state <= SH_IDLE;
            end
        endcase
    end
end

endmodule // fcd_download

// ===== testbench/fcd_download_checker.sv
// Purpose: Port-level assertions for the chip download serializer
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Bound to every instance of fcd_download
`timescale 1ns/1ps
module fcd_download_checker (
    input wire clk_sys,
    input wire rst_n,
    input wire bp_write,
    input wire bp_read,
    input wire bp_dtack,
    input wire bp_rvalid,
    input wire [7:0] chain_data,
    input wire [7:0] chain_clk,
    input wire init_mode,
    input wire config_lost
);
    // ----------------------------------------
    // Handshake and shift checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_write_take;
        bp_dtack && $past(bp_write);
    endsequence
    sequence s_read_take;
        bp_dtack && $past(bp_read) && !$past(bp_write);
    endsequence
    sequence s_all_shift;
        ##[2:30] chain_clk == 8'hff;
    endsequence
    a_dtack_single: assert property (bp_dtack |=> !bp_dtack) else $error("dtack too long");
    a_dtack_cause: assert property (bp_dtack |-> $past(bp_write || bp_read) && $past(init_mode))
        else $error("dtack without request");
    a_write_shift: assert property (s_write_take |-> s_all_shift) else $error("write gave no shift");
    a_read_answer: assert property (s_read_take |-> ##[2:40] bp_rvalid) else $error("read gave no data");
    a_clk_pulse: assert property (|chain_clk |=> chain_clk == 8'h00) else $error("chain clock too long");
    a_clk_shape: assert property (|chain_clk |-> chain_clk == 8'hff || $onehot(chain_clk))
        else $error("chain clock pattern wrong");
    a_data_hold: assert property (|chain_clk |-> ((chain_data ^ $past(chain_data)) & chain_clk) == 8'h00)
        else $error("data moved at clock");
    a_read_lost: assert property (bp_rvalid |-> config_lost && chain_clk == 8'hff)
        else $error("readback not destructive");
    a_lost_rise: assert property ($rose(config_lost) |-> bp_rvalid) else $error("lost flag without read");
endmodule // fcd_download_checker

bind fcd_download fcd_download_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .bp_write(bp_write),
    .bp_read(bp_read), .bp_dtack(bp_dtack), .bp_rvalid(bp_rvalid), .chain_data(chain_data),
    .chain_clk(chain_clk), .init_mode(init_mode), .config_lost(config_lost));

// ===== testbench/fcd_chain_model.sv
// Purpose: Eight daisy chains of front-end chips seen as shift registers
// Assumes: LEN is record bits times chips per chain
// Notes: A chain shifts on each sampled chain clock pulse
`timescale 1ns/1ps
module fcd_chain_model #(
    parameter LEN = 1820
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] chain_clk,
    input wire [7:0] chain_data,
    output logic [7:0] chain_return
);
    logic [LEN-1:0] sr [8];
    always @(posedge clk_sys or negedge rst_n) begin
        for (int c = 0; c < 8; c++) begin
            if (!rst_n) begin
                sr[c] <= '0;
            end else if (chain_clk[c]) begin
                sr[c] <= {sr[c][LEN-2:0], chain_data[c]};
            end
        end
    end
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            chain_return[c] = sr[c][LEN-1];
        end
    end
endmodule // fcd_chain_model

// ===== testbench/tb_fcd_download.sv
// Purpose: Self-checking bench for the chip download serializer
// Assumes: Short chains of two bits, serial word time of 20 cycles
// Notes: Reset case comes first; rows then drive the write loop; readback and link cases follow
`timescale 1ns/1ps
module tb_fcd_download;
    logic clk_sys, rst_n, download_enable, bp_write, bp_read, rt_word_valid, rt_word_is_cmd;
    logic bp_dtack, bp_rvalid, rt_overrun, init_mode, config_lost;
    logic [7:0] bp_wdata, bp_rdata, chain_data, chain_clk, chain_return;
    logic [4:0] rt_address;
    logic [3:0] rt_bit_select;
    logic [15:0] rt_word;
    logic [1:0] group_done;
    int error_cnt, checks, cyc, i;
    logic [7:0] rows [4] = '{8'ha5, 8'h3c, 8'h81, 8'h5a};
    logic [7:0] rd_exp [3] = '{8'h81, 8'h5a, 8'h00};

    fcd_download #(.REC_BITS(2), .CHIPS_PER_CHAIN(1), .WORD_CYC(20)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .download_enable(download_enable), .bp_write(bp_write), .bp_read(bp_read), .bp_wdata(bp_wdata),
        .bp_dtack(bp_dtack), .bp_rdata(bp_rdata), .bp_rvalid(bp_rvalid), .rt_address(rt_address),
        .rt_bit_select(rt_bit_select), .rt_word_valid(rt_word_valid), .rt_word_is_cmd(rt_word_is_cmd),
        .rt_word(rt_word), .rt_overrun(rt_overrun), .chain_return(chain_return), .chain_data(chain_data),
        .chain_clk(chain_clk), .init_mode(init_mode), .group_done(group_done), .config_lost(config_lost));
    fcd_chain_model #(.LEN(2)) chain (.clk_sys(clk_sys), .rst_n(rst_n), .chain_clk(chain_clk),
        .chain_data(chain_data), .chain_return(chain_return));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bp_req(input logic rd, input logic [7:0] d);
        int n;
        bp_write = !rd;
        bp_read = rd;
        bp_wdata = d;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (bp_dtack !== 1'b1 && n < 40);
        chk("bp_dtack", 16'h0001, {15'h0000, bp_dtack});
        bp_write = 0;
        bp_read = 0;
    endtask
    task automatic wait_on(input logic rv);
        int n;
        n = 0;
        do begin @(negedge clk_sys); n++; end while ((rv ? bp_rvalid : |chain_clk) !== 1'b1 && n < 40);
    endtask
    task automatic send(input logic cmd, input logic [15:0] w);
        rt_word_is_cmd = cmd;
        rt_word = w;
        rt_word_valid = 1;
        @(negedge clk_sys);
        rt_word_valid = 0;
    endtask
    task finish_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        {rst_n, download_enable, bp_write, bp_read, rt_word_valid, rt_word_is_cmd} = 6'h00;
        bp_wdata = 8'h00;
        rt_address = 5'h07;
        rt_bit_select = 4'h5;
        rt_word = 16'h0000;
        repeat (12) @(negedge clk_sys);
        chk("reset outputs", 16'h0000, {2'h0, bp_dtack, bp_rvalid, chain_clk, init_mode, group_done, config_lost});
        rst_n = 1;
        bp_write = 1;
        repeat (6) begin @(negedge clk_sys); chk("bp_dtack", 16'h0000, {15'h0000, bp_dtack}); end
        bp_write = 0;
        download_enable = 1;
        repeat (8) @(negedge clk_sys);
        chk("init_mode", 16'h0001, {15'h0000, init_mode});
        foreach (rows[i]) begin
            bp_req(0, rows[i]);
            wait_on(0);
            chk("chain_clk", 16'h00ff, {8'h00, chain_clk});
            chk("chain_data", {8'h00, rows[i]}, {8'h00, chain_data});
        end
        foreach (rd_exp[i]) begin
            repeat (10) @(negedge clk_sys);
            bp_req(1, 8'h00);
            wait_on(1);
            chk("bp_rdata", {8'h00, rd_exp[i]}, {8'h00, bp_rdata});
            chk("config_lost", 16'h0001, {15'h0000, config_lost});
        end
        bp_req(0, 8'h0f);
        repeat (6) @(negedge clk_sys);
        chk("config_lost", 16'h0000, {15'h0000, config_lost});
        send(1, {rt_address, 1'b0, 5'h01, 5'h00});
        repeat (4) @(negedge clk_sys);
        for (i = 0; i < 8; i++) begin
            send(0, (i % 2) ? 16'h0020 : 16'hffdf);
            wait_on(0);
            chk("chain_clk", 16'h0001 << (i / 2), {8'h00, chain_clk});
            chk("chain_data", 16'(i % 2), {15'h0000, chain_data[i / 2]});
        end
        repeat (48) @(negedge clk_sys);
        chk("group_done", 16'h0001, {14'h0000, group_done});
        chk("rt_overrun", 16'h0000, {15'h0000, rt_overrun});
        send(1, {rt_address, 1'b0, 5'h02, 5'h01});
        repeat (4) @(negedge clk_sys);
        send(0, 16'h0020);
        wait_on(0);
        chk("chain_clk", 16'h0010, {8'h00, chain_clk});
        chk("chain_data", 16'h0001, {15'h0000, chain_data[4]});
        repeat (4) @(negedge clk_sys);
        send(0, 16'h0020);
        repeat (8) begin @(negedge clk_sys); chk("chain_clk", 16'h0000, {8'h00, chain_clk}); end
        send(1, {5'h08, 1'b0, 5'h02, 5'h01});
        repeat (4) @(negedge clk_sys);
        send(0, 16'hffff);
        repeat (8) begin @(negedge clk_sys); chk("chain_clk", 16'h0000, {8'h00, chain_clk}); end
        send(1, {rt_address, 1'b0, 5'h02, 5'h00});
        repeat (4) @(negedge clk_sys);
        rt_word_is_cmd = 0;
        rt_word = 16'h0020;
        rt_word_valid = 1;
        repeat (4) @(negedge clk_sys);
        rt_word_valid = 0;
        repeat (12) @(negedge clk_sys);
        chk("rt_overrun", 16'h0001, {15'h0000, rt_overrun});
        finish_test();
    end
endmodule // tb_fcd_download
